/* File: hdl/triple_gp_timer_block.sv */
// three general-purpose 16-bit timers with shared action/direction register
// assumes requests on sys_clk; external clock and direction are asynchronous pins
//
// Contract
// - three independent timers serve as time bases
// - readable writable 16-bit counter, up or up/down
// - compare writes land in shadow copy
// - period writes land in shadow copy
// - each timer owns a 16-bit config register
// - selected clock passes a programmable prescaler
// - each timer drives its own compare pin
// - shared register writes leave status bits unchanged
// - shared register shows directions and event actions
// - direction bit reads 1 up, 0 down
// - direction pin high counts up, low down
// - working period reloads only at counter zero
module triple_gp_timer_block (
   // clock and reset
   input  wire logic                  sys_clk,
   input  wire logic                  srst,
   // register access
   input  wire gp_timer_pkg::reg_req_t req,
   output      logic [15:0]           rd_data,
   // pins
   input  wire logic                  external_timer_clock,
   input  wire logic                  external_count_direction,
   output      logic [2:0]            timer_compare_output_pin
);

   // ----------------------------------------------------------------
   // pin synchronisers
   // ----------------------------------------------------------------
   logic [2:0] clk_sync;        // stage 0 is read only by stage 1
   logic [1:0] dir_sync;        // stage 0 is read only by stage 1
   logic       ext_rise;        // one cycle per rising external clock edge
   logic       ext_dir;         // synchronised direction level
   logic [2:0] next_clk_sync;
   logic [1:0] next_dir_sync;

   // shift pin levels in; the third clock stage only feeds the edge detect
   always_comb begin
      next_clk_sync = {clk_sync[1:0], external_timer_clock};
      next_dir_sync = {dir_sync[0], external_count_direction};
   end

   always_ff @(posedge sys_clk) begin
      if (srst) begin
         clk_sync <= 3'h0;
         dir_sync <= 2'h0;
      end else begin
         clk_sync <= next_clk_sync;
         dir_sync <= next_dir_sync;
      end
   end

   // edges closer than two system cycles would merge here, hence the quarter-rate limit
   assign ext_rise = clk_sync[1] & ~clk_sync[2];
   assign ext_dir  = dir_sync[1];

   // ----------------------------------------------------------------
   // shared action control register
   // ----------------------------------------------------------------
   logic [12:0] shared;         // writable action bits
   logic [12:0] next_shared;
   logic        dir_q [3];      // per-timer counting direction, 1 = up
   logic [15:0] shared_view;    // what software reads back

   // status bits are not stored here, so a write cannot reach them
   always_comb begin
      next_shared = shared;
      if (req.wr && req.addr == gp_timer_pkg::SHARED_CTL_ADDR) begin
         next_shared = req.wdata[12:0];
      end
   end

   always_ff @(posedge sys_clk) begin
      if (srst) shared <= gp_timer_pkg::SHARED_RESET;
      else      shared <= next_shared;
   end

   assign shared_view = {dir_q[2], dir_q[1], dir_q[0], shared};

   // ----------------------------------------------------------------
   // per-timer logic
   // ----------------------------------------------------------------
   logic [15:0] cnt_q     [3];  // counter
   logic [15:0] cmp_sh_q  [3];  // compare shadow
   logic [15:0] cmp_act_q [3];  // compare working copy
   logic [15:0] per_sh_q  [3];  // period shadow
   logic [15:0] per_act_q [3];  // period working copy
   logic [15:0] cfg_q     [3];  // config register

   for (genvar t = 0; t < 3; t++) begin : g_timer
      logic [15:0]             next_cnt;
      logic [15:0]             next_cmp_sh;
      logic [15:0]             next_cmp_act;
      logic [15:0]             next_per_sh;
      logic [15:0]             next_per_act;
      logic [15:0]             next_cfg;
      logic                    next_dir;
      logic [6:0]              presc;      // prescale counter
      logic [6:0]              next_presc;
      logic                    active;     // compare output state
      logic                    next_active;
      logic                    pin_q;
      logic                    next_pin;
      logic [7:0]              step;
      logic [6:0]              mask;
      logic                    src_tick;
      logic                    cnt_tick;
      logic                    cmp_load;
      logic                    match;
      logic                    pmatch;
      gp_timer_pkg::mode_t     mode;
      gp_timer_pkg::reload_t   reload;
      gp_timer_pkg::polarity_t pol;
      logic                    en;
      logic                    cmp_en;

      assign mode   = gp_timer_pkg::mode_t'(cfg_q[t][gp_timer_pkg::CFG_MODE_LSB +: 2]);
      assign reload = gp_timer_pkg::reload_t'(cfg_q[t][gp_timer_pkg::CFG_RELOAD_LSB +: 2]);
      assign pol    = gp_timer_pkg::polarity_t'(shared[t*gp_timer_pkg::SHARED_POL_W +: 2]);
      assign en     = cfg_q[t][gp_timer_pkg::CFG_ENABLE_BIT];
      assign cmp_en = cfg_q[t][gp_timer_pkg::CFG_CMP_EN_BIT];

      // clock select and prescale: counter steps once per 2**n source ticks
      always_comb begin
         src_tick   = cfg_q[t][gp_timer_pkg::CFG_CLKSRC_BIT] ? ext_rise : 1'b1;
         step       = 8'h01 << cfg_q[t][gp_timer_pkg::CFG_PRESC_LSB +: 3];
         mask       = 7'(step - 8'h01);
         cnt_tick   = en && src_tick && ((presc & mask) == mask);
         next_presc = (en && src_tick) ? 7'(presc + 7'h01) : presc;
         if (!en) next_presc = gp_timer_pkg::PRESC_RESET;
      end

      // counter, direction and register writes
      always_comb begin
         next_cnt    = cnt_q[t];
         next_dir    = dir_q[t];
         next_cmp_sh = cmp_sh_q[t];
         next_per_sh = per_sh_q[t];
         next_cfg    = cfg_q[t];
         if (cnt_tick) begin
            case (mode)
               gp_timer_pkg::MODE_UP: begin
                  next_dir = 1'b1;
                  next_cnt = (cnt_q[t] >= per_act_q[t]) ? 16'h0000 : 16'(cnt_q[t] + 16'h0001);
               end
               gp_timer_pkg::MODE_DIR_UPDOWN: begin
                  next_dir = ext_dir;
                  if (ext_dir) begin
                     next_cnt = (cnt_q[t] >= per_act_q[t]) ? 16'h0000 : 16'(cnt_q[t] + 16'h0001);
                  end else begin
                     next_cnt = (cnt_q[t] == 16'h0000) ? per_act_q[t] : 16'(cnt_q[t] - 16'h0001);
                  end
               end
               gp_timer_pkg::MODE_CONT_UPDOWN: begin
                  // turn around at period and at zero; a zero period just holds
                  if (dir_q[t] && cnt_q[t] >= per_act_q[t]) begin
                     next_dir = 1'b0;
                     next_cnt = (cnt_q[t] == 16'h0000) ? cnt_q[t] : 16'(cnt_q[t] - 16'h0001);
                  end else if (!dir_q[t] && cnt_q[t] == 16'h0000) begin
                     next_dir = 1'b1;
                     next_cnt = (per_act_q[t] == 16'h0000) ? cnt_q[t] : 16'h0001;
                  end else if (dir_q[t]) begin
                     next_cnt = 16'(cnt_q[t] + 16'h0001);
                  end else begin
                     next_cnt = 16'(cnt_q[t] - 16'h0001);
                  end
               end
               default: begin
                  next_cnt = cnt_q[t];  // hold mode
               end
            endcase
         end
         // software access wins over counting in the same cycle
         if (req.wr) begin
            if (req.addr == gp_timer_pkg::COUNT_ADDR[t]) begin
               next_cnt = req.wdata;
            end else if (req.addr == gp_timer_pkg::MATCH_ADDR[t]) begin
               next_cmp_sh = req.wdata;
            end else if (req.addr == gp_timer_pkg::PERIOD_ADDR[t]) begin
               next_per_sh = req.wdata;
            end else if (req.addr == gp_timer_pkg::CONFIG_ADDR[t]) begin
               next_cfg = req.wdata;
            end
         end
      end

      // working copies: period only at zero, compare on the chosen event
      always_comb begin
         next_per_act = (cnt_q[t] == 16'h0000) ? next_per_sh : per_act_q[t];
         case (reload)
            gp_timer_pkg::RELOAD_ZERO:      cmp_load = cnt_q[t] == 16'h0000;
            gp_timer_pkg::RELOAD_ZERO_PER:  cmp_load = cnt_q[t] == 16'h0000 || cnt_q[t] == per_act_q[t];
            gp_timer_pkg::RELOAD_IMMEDIATE: cmp_load = 1'b1;
            default:                        cmp_load = 1'b0;
         endcase
         // a disabled compare is transparent
         if (!cmp_en) cmp_load = 1'b1;
         next_cmp_act = cmp_load ? next_cmp_sh : cmp_act_q[t];
      end

      // compare output: set on match, cleared on period match (up) or second match (up/down)
      always_comb begin
         match       = cmp_en && cnt_tick && next_cnt == cmp_act_q[t];
         pmatch      = cnt_tick && next_cnt == per_act_q[t];
         next_active = active;
         if (!cmp_en) begin
            next_active = 1'b0;
         end else if (mode == gp_timer_pkg::MODE_UP) begin
            if (match)       next_active = 1'b1;
            else if (pmatch) next_active = 1'b0;
         end else if (match) begin
            next_active = ~active;
         end
         case (pol)
            gp_timer_pkg::POL_FORCE_HIGH: next_pin = 1'b1;
            gp_timer_pkg::POL_ACT_HIGH:   next_pin = next_active;
            gp_timer_pkg::POL_ACT_LOW:    next_pin = ~next_active;
            default:                      next_pin = 1'b0;
         endcase
      end

      always_ff @(posedge sys_clk) begin
         if (srst) begin
            cnt_q[t]     <= gp_timer_pkg::COUNT_RESET;
            cmp_sh_q[t]  <= gp_timer_pkg::MATCH_RESET;
            cmp_act_q[t] <= gp_timer_pkg::MATCH_RESET;
            per_sh_q[t]  <= gp_timer_pkg::PERIOD_RESET;
            per_act_q[t] <= gp_timer_pkg::PERIOD_RESET;
            cfg_q[t]     <= gp_timer_pkg::CONFIG_RESET;
            dir_q[t]     <= 1'b1;
            presc        <= gp_timer_pkg::PRESC_RESET;
            active       <= 1'b0;
            pin_q        <= 1'b0;
         end else begin
            cnt_q[t]     <= next_cnt;
            cmp_sh_q[t]  <= next_cmp_sh;
            cmp_act_q[t] <= next_cmp_act;
            per_sh_q[t]  <= next_per_sh;
            per_act_q[t] <= next_per_act;
            cfg_q[t]     <= next_cfg;
            dir_q[t]     <= next_dir;
            presc        <= next_presc;
            active       <= next_active;
            pin_q        <= next_pin;
         end
      end

      assign timer_compare_output_pin[t] = pin_q;
   end

   // ----------------------------------------------------------------
   // read path, one cycle latency
   // ----------------------------------------------------------------
   logic [15:0] next_rd_data;

   // reads return the shadow of compare and period, as software wrote them
   always_comb begin
      next_rd_data = rd_data;
      if (req.rd) begin
         next_rd_data = 16'h0000;  // unmapped words read zero
         if (req.addr == gp_timer_pkg::SHARED_CTL_ADDR) begin
            next_rd_data = shared_view;
         end
         for (int i = 0; i < 3; i++) begin
            if (req.addr == gp_timer_pkg::COUNT_ADDR[i]) begin
               next_rd_data = cnt_q[i];
            end else if (req.addr == gp_timer_pkg::MATCH_ADDR[i]) begin
               next_rd_data = cmp_sh_q[i];
            end else if (req.addr == gp_timer_pkg::PERIOD_ADDR[i]) begin
               next_rd_data = per_sh_q[i];
            end else if (req.addr == gp_timer_pkg::CONFIG_ADDR[i]) begin
               next_rd_data = cfg_q[i];
            end
         end
      end
   end

   always_ff @(posedge sys_clk) begin
      if (srst) rd_data <= 16'h0000;
      else      rd_data <= next_rd_data;
   end

endmodule : triple_gp_timer_block

/* File: hdl/gp_timer_pkg.sv */
// constants, field layouts and carrier types for the three-timer block
// assumes one 25 MHz system clock and a 16-bit data-memory style register port
package gp_timer_pkg;

   // ----------------------------------------------------------------
   // register word addresses, index 0/1/2 is timer 1/2/3
   // ----------------------------------------------------------------
   localparam logic [15:0]      SHARED_CTL_ADDR = 16'h7400;
   localparam logic [2:0][15:0] COUNT_ADDR      = {16'h7409, 16'h7405, 16'h7401};
   localparam logic [2:0][15:0] MATCH_ADDR      = {16'h740A, 16'h7406, 16'h7402};
   localparam logic [2:0][15:0] PERIOD_ADDR     = {16'h740B, 16'h7407, 16'h7403};
   localparam logic [2:0][15:0] CONFIG_ADDR     = {16'h740C, 16'h7408, 16'h7404};

   // ----------------------------------------------------------------
   // field positions
   // ----------------------------------------------------------------
   localparam int CFG_CMP_EN_BIT  = 1;   // compare operation enable
   localparam int CFG_RELOAD_LSB  = 2;   // two bits, compare reload condition
   localparam int CFG_CLKSRC_BIT  = 4;   // 1 selects the external clock
   localparam int CFG_ENABLE_BIT  = 6;   // counting enable
   localparam int CFG_PRESC_LSB   = 8;   // three bits, divide by 2**n
   localparam int CFG_MODE_LSB    = 11;  // two bits, counting mode
   localparam int SHARED_DIR_LSB  = 13;  // three read-only direction bits
   localparam int SHARED_POL_W    = 2;   // output polarity field per timer

   // ----------------------------------------------------------------
   // reset values
   // ----------------------------------------------------------------
   localparam logic [15:0] CONFIG_RESET = 16'h0000;
   localparam logic [12:0] SHARED_RESET = 13'h0000;
   localparam logic [15:0] COUNT_RESET  = 16'h0000;
   localparam logic [15:0] MATCH_RESET  = 16'h0000;
   localparam logic [15:0] PERIOD_RESET = 16'h0000;
   localparam logic [6:0]  PRESC_RESET  = 7'h00;

   // ----------------------------------------------------------------
   // enumerations
   // ----------------------------------------------------------------
   typedef enum logic [1:0] {
      MODE_HOLD        = 2'h0,  // counter stopped, value kept
      MODE_UP          = 2'h1,  // continuous up, wraps at period
      MODE_DIR_UPDOWN  = 2'h2,  // direction from the external pin
      MODE_CONT_UPDOWN = 2'h3   // triangle between zero and period
   } mode_t;

   typedef enum logic [1:0] {
      RELOAD_ZERO      = 2'h0,
      RELOAD_ZERO_PER  = 2'h1,
      RELOAD_IMMEDIATE = 2'h2,
      RELOAD_NONE      = 2'h3
   } reload_t;

   typedef enum logic [1:0] {
      POL_FORCE_LOW  = 2'h0,
      POL_ACT_LOW    = 2'h1,
      POL_ACT_HIGH   = 2'h2,
      POL_FORCE_HIGH = 2'h3
   } polarity_t;

   // one register access request, valid for one cycle
   typedef struct packed {
      logic [15:0] addr;
      logic        wr;
      logic        rd;
      logic [15:0] wdata;
   } reg_req_t;

endpackage : gp_timer_pkg

/* File: dv/gp_timer_sva.sv */
// port-level checker for the three-timer block
// assumes it is bound onto triple_gp_timer_block, one clock domain
module gp_timer_sva (
   // clock and reset
   input wire logic                   sys_clk,
   input wire logic                   srst,
   // register port
   input wire gp_timer_pkg::reg_req_t req,
   input wire logic [15:0]            rd_data,
   // pins
   input wire logic [2:0]             timer_compare_output_pin
);
   // -----------------------------------------------------------
   // helpers
   // -----------------------------------------------------------
   // compare, period and config words read back what was written; counts move
   function automatic logic stored_word(logic [15:0] a);
      return (a > 16'h7401) && (a <= 16'h740C) && (a[1:0] != 2'h1);
   endfunction : stored_word

   default clocking @(posedge sys_clk); endclocking
   default disable iff (srst);

   // -----------------------------------------------------------
   // assertions
   // -----------------------------------------------------------
   rd_hold_a: assert property (!req.rd |=> $stable(rd_data))
      else $error("read data moved without a read");
   unmapped_zero_a: assert property (req.rd && !req.wr && (req.addr < 16'h7400 || req.addr > 16'h740C)
      |=> rd_data == 16'h0000) else $error("unmapped read not zero");
   reset_clear_a: assert property ($fell(srst) |-> rd_data == 16'h0000 && timer_compare_output_pin == 3'h0)
      else $error("outputs not cleared by reset");
   dir_reset_a: assert property ($fell(srst) && req.rd && req.addr == 16'h7400 |=> rd_data[15:13] == 3'h7)
      else $error("direction bits not up after reset");
   shadow_read_a: assert property (req.wr && stored_word(req.addr) ##1 !req.wr
      ##1 (req.rd && !req.wr && req.addr == $past(req.addr, 2)) |=> rd_data == $past(req.wdata, 3))
      else $error("stored word not read back");
   spare_store_a: assert property (req.wr && req.addr == 16'h7400 ##1 !req.wr
      ##1 (req.rd && !req.wr && req.addr == 16'h7400)
      |=> (rd_data & 16'h1FFF) == ($past(req.wdata, 3) & 16'h1FFF)) else $error("shared bits lost");
   forced_high_a: assert property (req.wr && req.addr == 16'h7400 && req.wdata[5:0] == 6'h3F
      |-> ##[1:3] timer_compare_output_pin == 3'h7) else $error("pins not forced high");
   forced_low_a: assert property (req.wr && req.addr == 16'h7400 && req.wdata[5:0] == 6'h00
      |-> ##[1:3] timer_compare_output_pin == 3'h0) else $error("pins not forced low");
endmodule : gp_timer_sva

/* File: dv/test_triple_gp_timer_block.sv */
// self-checking bench for the three-timer block
// assumes the package and design are compiled first
module test_triple_gp_timer_block;
   timeunit 1ns;
   timeprecision 1ns;
   // -----------------------------------------------------------
   // signals and model state
   // -----------------------------------------------------------
   logic                   sys_clk     = 1'b0;
   logic                   srst        = 1'b1;
   gp_timer_pkg::reg_req_t req         = '0;
   logic                   ext_clk     = 1'b0;  // external timer clock
   logic                   ext_dir     = 1'b1;  // external direction
   logic [15:0]            rd_data;
   logic [2:0]             pins;
   int                     miscompares = 0;
   int                     n_checks    = 0;
   int                     seed        = 83861;
   logic [15:0]            mdl [int];           // expected word per address
   logic [15:0]            v, w, a;
   int                     wp, sp;              // model working and shadow period
   bit                     above;               // count passed the new period
   int                     mc;                  // model count for the triangle run
   bit                     md, mp;              // model direction and compare pin

   always #20 sys_clk = ~sys_clk;
   // one eighth of the system clock keeps the source slow enough
   always begin
      repeat (4) @(posedge sys_clk);
      ext_clk <= ~ext_clk;
   end

   triple_gp_timer_block u_dut (
      .sys_clk                  (sys_clk),
      .srst                     (srst),
      .req                      (req),
      .rd_data                  (rd_data),
      .external_timer_clock     (ext_clk),
      .external_count_direction (ext_dir),
      .timer_compare_output_pin (pins)
   );

   // -----------------------------------------------------------
   // tasks: bus cycles, compare, closing
   // -----------------------------------------------------------
   task automatic wr(input logic [15:0] ad, input logic [15:0] d);
      @(posedge sys_clk);
      req <= '{addr: ad, wr: 1'b1, rd: 1'b0, wdata: d};
      @(posedge sys_clk);
      req <= '0;
   endtask : wr
   // data is taken mid-cycle after the taking edge
   task automatic rd(input logic [15:0] ad, output logic [15:0] d);
      @(posedge sys_clk);
      req <= '{addr: ad, wr: 1'b0, rd: 1'b1, wdata: 16'h0000};
      @(posedge sys_clk);
      req <= '0;
      @(negedge sys_clk);
      d = rd_data;
   endtask : rd
   task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
      n_checks++;
      if (g !== e) begin
         miscompares++;
         $display("wrong value %s expected %h seen %h", nm, e, g);
      end
   endtask : chk
   task automatic end_of_test();
      $display("checks %0d miscompares %0d", n_checks, miscompares);
      if (miscompares == 0 && n_checks > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask : end_of_test

   // hang guard
   initial begin
      repeat (20000) @(posedge sys_clk);
      miscompares++;
      end_of_test();
   end

   // -----------------------------------------------------------
   // main sequence
   // -----------------------------------------------------------
   initial begin
      repeat (3) @(posedge sys_clk);
      srst <= 1'b0;
      req  <= '{addr: 16'h7400, wr: 1'b0, rd: 1'b1, wdata: 16'h0000};
      @(posedge sys_clk);
      req <= '0;
      @(negedge sys_clk);
      chk("shared at reset", 16'hE000, rd_data);
      for (int i = 1; i < 13; i++) begin
         rd(16'h7400 + 16'(i), v);
         chk("word at reset", 16'h0000, v);
      end
      wr(16'h740D, 16'hFFFF);
      rd(16'h740D, v);
      chk("unmapped", 16'h0000, v);
      // random words, timers left disabled in hold mode
      for (int t = 0; t < 3; t++) begin
         for (int k = 0; k < 4; k++) begin
            a = 16'h7401 + 16'(4 * t + k);
            w = 16'($random(seed));
            if (k == 3) w = w & 16'hE7BF;
            mdl[a] = w;
            wr(a, w);
            // count words are checked in the stored-word sweep, the rest must read straight back
            if (k != 0) begin
               rd(a, v);
               chk("word readback", w, v);
            end
         end
      end
      foreach (mdl[ad]) begin
         rd(16'(ad), v);
         chk("stored word", mdl[ad], v);
      end
      // status bits ignore writes, polarity forces pins
      wr(16'h7400, 16'hFFFF);
      rd(16'h7400, v);
      chk("shared all ones", 16'hFFFF, v);
      chk("pins forced high", 16'h0007, {13'h0000, pins});
      wr(16'h7400, 16'h0000);
      rd(16'h7400, v);
      chk("status kept", 16'hE000, v);
      chk("pins forced low", 16'h0000, {13'h0000, pins});
      // timer 1 up count: new period waits for a zero count
      wr(16'h7404, 16'h0000);
      wr(16'h7401, 16'h0000);
      wr(16'h7403, 16'h0009);
      wr(16'h7401, 16'h0003);
      wr(16'h7403, 16'h0004);
      wr(16'h7404, 16'h0840);
      wp = 9;
      sp = 4;
      above = 0;
      rd(16'h7401, v);
      for (int i = 0; i < 12; i++) begin
         w = v;
         repeat (2) begin
            w = (w >= wp) ? 16'h0000 : w + 16'h0001;
            if (w == 0) wp = sp;
         end
         rd(16'h7401, v);
         if (v > 16'h0004 && wp == 9) above = 1;
         chk("up count", w, v);
      end
      chk("old period kept", 16'h0001, 16'(above));
      // timer 2 prescaler, divide by 1 to 8
      for (int n = 0; n < 4; n++) begin
         wr(16'h7408, 16'h0000);
         wr(16'h7405, 16'h0000);
         wr(16'h7407, 16'hFFFF);
         wr(16'h7408, 16'h0840 | 16'(n << 8));
         rd(16'h7405, v);
         repeat (14) @(posedge sys_clk);
         rd(16'h7405, w);
         chk("prescaled steps", 16'(16 >> n), w - v);
      end
      // timer 3 directional mode on the external clock
      wr(16'h7409, 16'h0000);
      wr(16'h740B, 16'hFFFF);
      wr(16'h7409, 16'h0100);
      wr(16'h740C, 16'h1050);
      for (int d = 0; d < 2; d++) begin
         @(posedge sys_clk);
         ext_dir <= d[0];
         // direction only moves on a counted edge, so wait past one external period
         repeat (20) @(posedge sys_clk);
         rd(16'h7400, v);
         chk("direction bits", {d[0], 15'h6000}, v & 16'hE000);
         rd(16'h7409, v);
         repeat (30) @(posedge sys_clk);
         rd(16'h7409, w);
         chk("external steps", (d == 1) ? 16'h0004 : 16'hFFFC, w - v);
      end
      // timer 1 continuous up/down, compare at 3, pin active high
      wr(16'h7404, 16'h0000);
      wr(16'h7401, 16'h0000);
      wr(16'h7403, 16'h0006);
      wr(16'h7402, 16'h0003);
      wr(16'h7400, 16'h0002);
      wr(16'h7404, 16'h1842);
      mc = 0;
      md = 1;
      mp = 0;
      for (int i = 0; i < 30; i++) begin
         @(negedge sys_clk);
         chk("timer1 pin", {15'h0000, mp}, {15'h0000, pins[0]});
         // triangle model: turn at period and at zero, toggle on stepping onto compare
         if (md && mc >= 6) begin
            md = 0;
            mc = mc - 1;
         end else if (!md && mc == 0) begin
            md = 1;
            mc = mc + 1;
         end else begin
            mc = md ? mc + 1 : mc - 1;
         end
         if (mc == 3) mp = ~mp;
      end
      end_of_test();
   end
endmodule : test_triple_gp_timer_block

bind triple_gp_timer_block gp_timer_sva u_sva (
   .sys_clk                  (sys_clk),
   .srst                     (srst),
   .req                      (req),
   .rd_data                  (rd_data),
   .timer_compare_output_pin (timer_compare_output_pin)
);
